// >>> design/otp_programming_port.v
// Programming-mode port of the one-time programmable code memory
//
// Summary of operation
// - 32 Kbyte array, 15-bit byte address
// - One byte programmed in about 100 us
// - Device is passive slave; programmer drives all
// - Select 01 signature, 10 lock, 11 memory
// - High address captured on latch strobe fall
// - High bits first, then low byte, shared port
// - Write strobe pulse triggers byte/lock programming
// - Read strobe gates memory and lock reads
// - Bidirectional 8-bit data port
// - Two lock bits, four levels, erased is one
// - Level 1 blocks programming, level 2 reads
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "otp_port_consts.vh"

module otp_programming_port #(
  parameter SIG_BYTE0 = 8'h5a, // Arbitrary identity value
  parameter SIG_BYTE1 = 8'h3c, // Arbitrary identity value
  parameter SIG_BYTE2 = 8'h01 // Arbitrary identity value
) (
  input wire clock_in,
  input wire rst_in,
  // Programmer pins
  input wire reset_pin_in,
  input wire code_store_enable_input_in,
  input wire access_mode_select_lo_in,
  input wire access_mode_select_hi_in,
  input wire high_address_latch_strobe_in,
  input wire read_strobe_n_in,
  input wire write_strobe_n_in,
  input wire high_voltage_select_pin_in,
  input wire [7:0] address_port_in,
  input wire [7:0] data_port_lines_in,
  output reg [7:0] data_port_lines_out,
  output reg data_port_lines_oe_n_out,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out
);

  // Program cycle length in clock cycles, rounded down as a longest time
  localparam integer WRITE_STROBE_COUNT = `WRITE_STROBE_TIME_NS / `CLOCK_PERIOD_NS;
  localparam [11:0] WRITE_STROBE_CYCLES = WRITE_STROBE_COUNT[11:0];
  // Program sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_BURN = 2'h2;
  localparam [1:0] ST_COMMIT = 2'h3;
  reg [1:0] state_reg, state_next; // Sequencer state
  reg [11:0] timer_reg, timer_next; // Program cycle timer
  reg [6:0] high_addr_reg; // Latched high address bits
  reg [1:0] mode_reg; // Access mode taken at strobe rise
  reg [1:0] lock_reg; // Lock bits, kept across reset
  reg ale_prev_reg; // Latch strobe one cycle ago
  reg wr_prev_reg; // Write strobe one cycle ago
  reg [14:0] write_strobe_addr_reg; // Address of the byte being burned
  reg [7:0] write_strobe_data_reg; // Data being burned
  reg write_strobe_lock_reg; // Current cycle targets lock bits
  reg enable_reg; // Software enable for the port
  reg refused_reg; // Sticky: write refused
  reg [14:0] last_addr_reg; // Last programmed address
  reg mem_write; // Array write strobe
  reg [7:0] mem_wdata; // Array write data
  wire [7:0] mem_rdata; // Array read data
  wire [14:0] cur_addr; // Full address: latched high bits, live low byte
  wire active; // Programming mode conditions met
  wire wr_fall; // Write strobe pulse start
  wire read_locked; // Verification reads blocked
  wire write_strobe_locked; // Further programming blocked
  wire avs_hit; // Bus request being answered
  reg [7:0] read_byte; // Byte that a read would return
  reg read_drive; // Read access owns the data port

  // Software enable and pin-level qualifiers for the mode
  assign active = enable_reg & reset_pin_in & ~code_store_enable_input_in;
  // High bits latched earlier, low byte live on the shared port
  assign cur_addr = {high_addr_reg, address_port_in};
  assign wr_fall = wr_prev_reg & ~write_strobe_n_in;
  // Level 2 and above: upper lock bit programmed
  assign read_locked = ~lock_reg[1];
  // Level 1 and above: any lock bit programmed
  assign write_strobe_locked = (lock_reg != `LOCK_UNPROGRAMMED);
  assign avs_hit = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  // Code array; address follows the pins unless a burn owns it
  otp_byte_array #(
    .ADDR_W(`OTP_ADDR_W),
    .DATA_W(`OTP_DATA_W)
  ) array_inst (
    .clock_in(clock_in),
    .addr_in((state_reg == ST_IDLE) ? cur_addr : write_strobe_addr_reg),
    .write_in(mem_write),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );
  // Lock bits are nonvolatile: erased at power-up, untouched by reset
  initial begin
    lock_reg = `LOCK_UNPROGRAMMED;
  end

  // Strobe edge trackers, address latch and mode latch
  always @(posedge clock_in) begin
    if (rst_in) begin
      ale_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
      high_addr_reg <= 7'h00;
      mode_reg <= `MODE_RESERVED;
    end else begin
      ale_prev_reg <= high_address_latch_strobe_in;
      wr_prev_reg <= write_strobe_n_in;
      // Falling edge: high address bits captured and held
      if (ale_prev_reg & ~high_address_latch_strobe_in) begin
        high_addr_reg <= address_port_in[6:0];
      end
      // Rising edge: select is stable here, so take it
      if (~ale_prev_reg & high_address_latch_strobe_in) begin
        mode_reg <= {access_mode_select_hi_in, access_mode_select_lo_in};
      end
    end
  end

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    mem_write = 1'b0;
    mem_wdata = write_strobe_data_reg;
    case (state_reg)
      ST_IDLE: begin
        timer_next = 12'h000;
      end
      ST_FETCH: begin
        // Array read of the old byte lands this cycle
        state_next = ST_BURN;
      end
      ST_BURN: begin
        // Cycle runs its full length regardless of the pins
        if (timer_reg == WRITE_STROBE_CYCLES - 12'h001) begin
          state_next = ST_COMMIT;
        end else begin
          timer_next = timer_reg + 12'h001;
        end
      end
      ST_COMMIT: begin
        // Programming can only clear bits, never set them
        mem_write = ~write_strobe_lock_reg;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and cycle start
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      timer_reg <= 12'h000;
      write_strobe_addr_reg <= 15'h0000;
      write_strobe_data_reg <= `OTP_ERASED_BYTE;
      write_strobe_lock_reg <= 1'b0;
      refused_reg <= 1'b0;
      last_addr_reg <= 15'h0000;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      // Old byte arrives from the array: merge with the new data
      if (state_reg == ST_FETCH) begin
        write_strobe_data_reg <= write_strobe_data_reg & mem_rdata;
      end
      if (state_reg == ST_COMMIT) begin
        if (write_strobe_lock_reg) begin
          lock_reg <= lock_reg & write_strobe_data_reg[1:0];
        end else begin
          last_addr_reg <= write_strobe_addr_reg;
        end
      end
      // Write one to clear; a refusal below in the same cycle wins
      if (avs_hit & avs_write_in & (avs_address_in == `REG_STATUS) &
          avs_writedata_in[`STAT_REFUSED_BIT]) begin
        refused_reg <= 1'b0;
      end
      // Write pulse with programming voltage present
      if (active & wr_fall & high_voltage_select_pin_in) begin
        if (state_reg != ST_IDLE) begin
          refused_reg <= 1'b1;
        end else if (mode_reg == `MODE_MEMORY) begin
          if (write_strobe_locked) begin
            refused_reg <= 1'b1;
          end else begin
            write_strobe_addr_reg <= cur_addr;
            write_strobe_data_reg <= data_port_lines_in;
            write_strobe_lock_reg <= 1'b0;
            state_reg <= ST_FETCH;
          end
        end else if (mode_reg == `MODE_LOCK) begin
          write_strobe_data_reg <= data_port_lines_in;
          write_strobe_lock_reg <= 1'b1;
          state_reg <= ST_BURN;
        end else begin
          refused_reg <= 1'b1;
        end
      end
    end
  end

  // Byte a read would return in the current mode
  always @* begin
    read_byte = `OTP_ERASED_BYTE;
    read_drive = 1'b0;
    case (mode_reg)
      `MODE_MEMORY: begin
        read_drive = 1'b1;
        // Level 2 parts answer erased data instead of the array
        read_byte = read_locked ? `OTP_ERASED_BYTE : mem_rdata;
      end
      `MODE_LOCK: begin
        read_drive = 1'b1;
        read_byte = {6'h3f, lock_reg};
      end
      `MODE_SIGNATURE: begin
        read_drive = 1'b1;
        if (address_port_in == `SIG_ADDR0) begin
          read_byte = SIG_BYTE0;
        end else if (address_port_in == `SIG_ADDR1) begin
          read_byte = SIG_BYTE1;
        end else if (address_port_in == `SIG_ADDR2) begin
          read_byte = SIG_BYTE2;
        end else begin
          read_byte = 8'h00;
        end
      end
      default: begin
        read_drive = 1'b0; // Reserved mode never drives
      end
    endcase
  end

  // Data port driver; released whenever no read owns it
  always @(posedge clock_in) begin
    if (rst_in) begin
      data_port_lines_out <= 8'h00;
      data_port_lines_oe_n_out <= 1'b1;
    end else begin
      data_port_lines_out <= read_byte;
      // Voltage pin is ignored for reads: logic high is all that is expected
      data_port_lines_oe_n_out <= ~(active & ~read_strobe_n_in & read_drive &
                                    (state_reg == ST_IDLE));
    end
  end

  // Avalon slave: one wait cycle, then answer
  always @(posedge clock_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
      enable_reg <= 1'b0;
    end else begin
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
      if ((avs_read_in | avs_write_in) & avs_waitrequest_out) begin
        case (avs_address_in)
          `REG_CONTROL: begin
            avs_readdata_out <= {31'h00000000, enable_reg};
          end
          `REG_STATUS: begin
            avs_readdata_out <= {25'h0000000, active, mode_reg, lock_reg,
                                 refused_reg, (state_reg != ST_IDLE)};
          end
          `REG_LAST_ADDR: begin
            avs_readdata_out <= {17'h00000, last_addr_reg};
          end
          default: begin
            avs_readdata_out <= 32'h00000000;
          end
        endcase
      end
      if (avs_hit & avs_write_in & (avs_address_in == `REG_CONTROL)) begin
        enable_reg <= avs_writedata_in[`CTRL_ENABLE_BIT];
      end
    end
  end

endmodule // otp_programming_port

// >>> design/otp_port_consts.vh
// Constants for the one-time programmable code memory programming port
`ifndef OTP_PORT_CONSTS_VH
`define OTP_PORT_CONSTS_VH

// Memory geometry
`define OTP_ADDR_W 15
`define OTP_DATA_W 8
`define OTP_HIGH_BITS 7
`define OTP_ERASED_BYTE 8'hff

// Access modes, {select_hi, select_lo}
`define MODE_RESERVED 2'h0
`define MODE_SIGNATURE 2'h1
`define MODE_LOCK 2'h2
`define MODE_MEMORY 2'h3

// Lock bits, unprogrammed bit reads as one
`define LOCK_UNPROGRAMMED 2'h3

// Signature byte addresses
`define SIG_ADDR0 8'hfc
`define SIG_ADDR1 8'hfd
`define SIG_ADDR2 8'hfe

// Program cycle time
`define WRITE_STROBE_TIME_NS 100000
`define CLOCK_PERIOD_NS 25

// Avalon register byte addresses
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_LAST_ADDR 4'h8

// Field positions
`define CTRL_ENABLE_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_REFUSED_BIT 1
`define STAT_LOCK_LSB 2
`define STAT_MODE_LSB 4
`define STAT_ACTIVE_BIT 6

`endif

// >>> design/otp_byte_array.v
// Byte-wide code memory with registered read data
`timescale 1ns/1ps

module otp_byte_array #(
  parameter ADDR_W = 15,
  parameter DATA_W = 8
) (
  input wire clock_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire write_in,
  input wire [DATA_W-1:0] wdata_in,
  output reg [DATA_W-1:0] rdata_out
);

  // Storage cells
  reg [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
  integer i;

  // Blank part: every cell starts erased
  initial begin
    for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
      cells[i] = {DATA_W{1'b1}};
    end
    rdata_out = {DATA_W{1'b1}};
  end

  // One write port, read data from a register
  always @(posedge clock_in) begin
    if (write_in) begin
      cells[addr_in] <= wdata_in;
    end
    rdata_out <= cells[addr_in];
  end

endmodule // otp_byte_array

// >>> bench/otp_port_props.sv
// Checker for the programming port pins and bus
`timescale 1ns/1ps
module otp_port_props #(
  parameter SIG_BYTE0 = 8'h5a
) (
  input wire clock_in,
  input wire rst_in,
  input wire reset_pin_in,
  input wire code_store_enable_input_in,
  input wire access_mode_select_lo_in,
  input wire access_mode_select_hi_in,
  input wire high_address_latch_strobe_in,
  input wire read_strobe_n_in,
  input wire [7:0] address_port_in,
  input wire [7:0] data_port_lines_out,
  input wire data_port_lines_oe_n_out,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire avs_waitrequest_out
);
  reg [1:0] mode_reg; // Mode taken at strobe rise
  reg ale_reg; // Previous latch strobe level
  // Mirror of the latched access mode
  always @(posedge clock_in) begin
    ale_reg <= high_address_latch_strobe_in;
    if (rst_in) begin
      mode_reg <= 2'h0;
    end else if (high_address_latch_strobe_in && !ale_reg) begin
      mode_reg <= {access_mode_select_hi_in, access_mode_select_lo_in};
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Three cycles of a steady read, so registered data has settled
  sequence s_sig_read;
    (mode_reg == 2'h1 && !data_port_lines_oe_n_out && address_port_in == 8'hfc) [*3];
  endsequence
  sequence s_lock_read;
    (mode_reg == 2'h2 && !data_port_lines_oe_n_out) [*3];
  endsequence
  sequence s_mode_idle;
    mode_reg == 2'h0 ##1 mode_reg == 2'h0;
  endsequence
  property p_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  property p_wait_cause;
    !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in) && $past(avs_waitrequest_out)
      ##1 avs_waitrequest_out;
  endproperty
  property p_oe_cause;
    !data_port_lines_oe_n_out |-> $past(!read_strobe_n_in);
  endproperty
  property p_oe_release;
    read_strobe_n_in |=> data_port_lines_oe_n_out;
  endproperty
  property p_inactive;
    !reset_pin_in || code_store_enable_input_in |=> data_port_lines_oe_n_out;
  endproperty
  property p_reserved;
    s_mode_idle |-> data_port_lines_oe_n_out;
  endproperty
  property p_sig;
    s_sig_read |-> data_port_lines_out == SIG_BYTE0;
  endproperty
  property p_lock;
    s_lock_read |-> data_port_lines_out[7:2] == 6'h3f;
  endproperty
  a_answer: assert property (p_answer) else $error("bus not answered next cycle");
  a_wait_cause: assert property (p_wait_cause) else $error("stray bus answer");
  a_oe_cause: assert property (p_oe_cause) else $error("drive without strobe");
  a_oe_release: assert property (p_oe_release) else $error("drive held");
  a_inactive: assert property (p_inactive) else $error("drive while inactive");
  a_reserved: assert property (p_reserved) else $error("drive in mode 00");
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  a_lock: assert property (p_lock) else $error("lock read upper bits");
endmodule // otp_port_props
bind otp_programming_port otp_port_props #(.SIG_BYTE0(SIG_BYTE0)) i_props (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .reset_pin_in(reset_pin_in),
  .code_store_enable_input_in(code_store_enable_input_in),
  .access_mode_select_lo_in(access_mode_select_lo_in),
  .access_mode_select_hi_in(access_mode_select_hi_in),
  .high_address_latch_strobe_in(high_address_latch_strobe_in),
  .read_strobe_n_in(read_strobe_n_in),
  .address_port_in(address_port_in),
  .data_port_lines_out(data_port_lines_out),
  .data_port_lines_oe_n_out(data_port_lines_oe_n_out),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out)
);

// >>> bench/otp_programmer_model.sv
// Programmer model driving the port pins
`timescale 1ns/1ps
module otp_programmer_model (
  input wire clock_in,
  input wire [7:0] dev_data_in,
  input wire dev_oe_n_in,
  output reg reset_pin_out,
  output reg store_en_out,
  output reg sel_lo_out,
  output reg sel_hi_out,
  output reg latch_out,
  output reg read_n_out,
  output reg write_n_out,
  output reg hv_out,
  output reg [7:0] addr_out,
  output wire [7:0] line_out
);
  reg drv_reg; // Programmer drives the data lines
  reg [7:0] wdat_reg; // Write data
  reg [7:0] junk_reg; // Released lines wander, never hold
  assign line_out = !dev_oe_n_in ? dev_data_in : drv_reg ? wdat_reg : junk_reg;
  // Entry state: write strobe and voltage pin low
  initial begin
    {reset_pin_out, store_en_out, write_n_out, hv_out} = 4'h8;
    {sel_lo_out, sel_hi_out, latch_out, read_n_out, drv_reg} = 5'h02;
    addr_out = 8'h00;
    wdat_reg = 8'h00;
    junk_reg = 8'h96;
  end
  // Pattern changes every cycle
  always @(posedge clock_in) junk_reg <= junk_reg + 8'h5b;
  // Leave the entry sequence
  task enter;
    @(posedge clock_in) write_n_out <= 1'b1;
  endtask
  // Mode with strobe low, then high bits, then low byte
  task setup(input [1:0] m, input [14:0] a);
    begin
      @(posedge clock_in) {sel_hi_out, sel_lo_out} <= m;
      @(posedge clock_in) latch_out <= 1'b1;
      @(posedge clock_in) {latch_out, addr_out} <= {1'b0, 1'b0, a[14:8]};
      @(posedge clock_in) addr_out <= a[7:0];
      @(posedge clock_in);
    end
  endtask
  // Write pulse with programming voltage up
  task write_strobe(input [7:0] d);
    begin
      @(posedge clock_in) {drv_reg, wdat_reg, hv_out} <= {1'b1, d, 1'b1};
      @(posedge clock_in) write_n_out <= 1'b0;
      @(posedge clock_in);
      @(posedge clock_in) write_n_out <= 1'b1;
      @(posedge clock_in) {drv_reg, hv_out} <= 2'h0;
    end
  endtask
  // Read gate, voltage pin at plain logic level
  task rd(output [7:0] d);
    begin
      @(posedge clock_in) read_n_out <= 1'b0;
      repeat (3) @(posedge clock_in);
      d = line_out;
      read_n_out <= 1'b1;
    end
  endtask
endmodule // otp_programmer_model

// >>> bench/otp_programming_port_test.sv
// Self-checking bench for the programming port
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module otp_programming_port_test;
  reg clock_in = 1'b0;
  reg rst_in = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd_r = 1'b0;
  reg wr_r = 1'b0;
  reg [31:0] wd = 32'h0;
  wire [31:0] rdata;
  wire wreq;
  wire [7:0] dout, line, pa;
  wire oe_n, rp, se, sl, sh, al, rn, wn, hv;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  reg [31:0] seed = 32'h126bc535;
  reg [31:0] r;
  reg [14:0] a;
  reg [7:0] d, d2, q;
  otp_programming_port i_dut (.clock_in(clock_in), .rst_in(rst_in), .reset_pin_in(rp),
    .code_store_enable_input_in(se), .access_mode_select_lo_in(sl),
    .access_mode_select_hi_in(sh), .high_address_latch_strobe_in(al),
    .read_strobe_n_in(rn), .write_strobe_n_in(wn), .high_voltage_select_pin_in(hv),
    .address_port_in(pa), .data_port_lines_in(line), .data_port_lines_out(dout),
    .data_port_lines_oe_n_out(oe_n), .avs_address_in(adr), .avs_read_in(rd_r),
    .avs_write_in(wr_r), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq));
  otp_programmer_model i_write_strobe (.clock_in(clock_in), .dev_data_in(dout), .dev_oe_n_in(oe_n),
    .reset_pin_out(rp), .store_en_out(se), .sel_lo_out(sl), .sel_hi_out(sh),
    .latch_out(al), .read_n_out(rn), .write_n_out(wn), .hv_out(hv), .addr_out(pa),
    .line_out(line));
  initial forever #12.5 clock_in = ~clock_in;
  // Expected signature bytes
  function automatic [7:0] sig(input [7:0] x);
    sig = (x == 8'hfc) ? 8'h5a : (x == 8'hfd) ? 8'h3c : (x == 8'hfe) ? 8'h01 : 8'h00;
  endfunction
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One bus cycle, held until waitrequest is seen low
  task bus(input w, input [3:0] ad, input [31:0] v, output [31:0] o);
    begin
      @(posedge clock_in) {adr, wd, wr_r, rd_r} <= {ad, v, w, !w};
      do @(posedge clock_in); while (wreq);
      o = rdata;
      {rd_r, wr_r} <= 2'h0;
    end
  endtask
  // Poll busy until the program cycle ends
  task idle;
    do bus(1'b0, 4'h4, 32'h0, r); while (r[0] !== 1'b0);
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    i_write_strobe.enter;
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[5:0], 6'h0c)
    bus(1'b0, 4'hc, 32'h0, r); `CHK(r, 32'h0)
    bus(1'b1, 4'h0, 32'h1, r);
    bus(1'b0, 4'h0, 32'h0, r); `CHK(r[0], 1'b1)
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      i_write_strobe.setup(2'h1, {7'h0, 8'hfc + i[7:0]});
      i_write_strobe.rd(q); `CHK(q, sig(8'hfc + i[7:0]))
    end
    i_write_strobe.setup(2'h0, 15'h00fc);
    i_write_strobe.rd(q); `CHK(oe_n, 1'b1)
    i_write_strobe.write_strobe(8'h00);
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[5:0], 6'h0e)
    bus(1'b1, 4'h4, 32'h2, r);
    $display("signature done");
    seed = lfsr(seed);
    {a, d} = {seed[14:0], seed[23:16]};
    seed = lfsr(seed);
    d2 = seed[7:0];
    i_write_strobe.setup(2'h3, a);
    t0 = cyc;
    i_write_strobe.write_strobe(d);
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[0], 1'b1)
    idle; `CHK(cyc - t0 > 3995 && cyc - t0 < 4020, 1'b1)
    bus(1'b0, 4'h8, 32'h0, r); `CHK(r[14:0], a)
    i_write_strobe.rd(q); `CHK(q, d)
    @(posedge clock_in) i_write_strobe.reset_pin_out <= 1'b0;
    i_write_strobe.rd(q); `CHK(oe_n, 1'b1)
    @(posedge clock_in) i_write_strobe.reset_pin_out <= 1'b1;
    i_write_strobe.write_strobe(d2);
    i_write_strobe.write_strobe(8'h00);
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[1:0], 2'h3)
    bus(1'b1, 4'h4, 32'h2, r);
    idle;
    i_write_strobe.rd(q); `CHK(q, d & d2)
    $display("memory done");
    i_write_strobe.setup(2'h1, 15'h0);
    i_write_strobe.write_strobe(8'h00);
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[1:0], 2'h2)
    bus(1'b1, 4'h4, 32'h2, r);
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[1], 1'b0)
    i_write_strobe.setup(2'h2, 15'h0);
    i_write_strobe.write_strobe(8'hfe);
    idle;
    i_write_strobe.rd(q); `CHK(q, 8'hfe)
    i_write_strobe.setup(2'h3, a);
    i_write_strobe.write_strobe(8'h00);
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[1:0], 2'h2)
    i_write_strobe.rd(q); `CHK(q, d & d2)
    i_write_strobe.setup(2'h2, 15'h0);
    i_write_strobe.write_strobe(8'hfd);
    idle;
    i_write_strobe.setup(2'h3, a);
    i_write_strobe.rd(q); `CHK(q, 8'hff)
    $display("lock done");
    @(posedge clock_in) rst_in <= 1'b1;
    @(posedge clock_in) rst_in <= 1'b0;
    bus(1'b0, 4'h4, 32'h0, r); `CHK(r[6:0], 7'h00)
    $display("reset done");
    conclude;
  end
endmodule // otp_programming_port_test
